/* File: dio_module_supervisor.sv */
// Supervisor of a networked digital I/O module.
`timescale 1ns/1ps
`include "dio_supervisor_cfg.svh"
module dio_module_supervisor #(
   parameter int MODWD_CYC    = `MS_CYC(`MODWD_MS),
   parameter int HWD_UNIT_CYC = `MS_CYC(`HWD_UNIT_MS),
   parameter int FLASH_CYC    = `MS_CYC(`FLASH_MS)
) (
   input  wire logic                        clk,
   input  wire logic                        rst_b,
   input  wire logic                        initStrap_b,
   input  wire logic [`NCH-1:0]             din,
   input  wire logic                        aliveKick,
   input  wire logic [7:0]                  nvId,
   input  wire logic [17:0]                 nvBaud,
   input  wire logic                        nvChk,
   input  wire logic [`NCH-1:0]             nvPowerOn,
   input  wire logic [`NCH-1:0]             nvSafe,
   input  wire logic [7:0]                  dataFormatField,
   input  wire logic                        reqValid,
   output      logic                        reqReady,
   input  wire logic [7:0]                  reqFunc,
   input  wire logic [7:0]                  reqSub,
   input  wire logic [7:0]                  reqData,
   output      logic                        respValid,
   input  wire logic                        respReady,
   output      logic [7:0]                  respByte,
   output      logic                        respLast,
   input  wire logic                        cmdValid,
   input  wire dio_supervisor_pkg::cmd_e    cmdCode,
   input  wire logic [2:0]                  cmdChan,
   input  wire logic [7:0]                  cmdData,
   input  wire logic [7:0]                  cmdId,
   output      logic                        ansValid,
   output      logic [15:0]                 ansData,
   output      logic                        cfgWrStrobe,
   output      logic [7:0]                  effId,
   output      logic [17:0]                 effBaud,
   output      logic                        effChk,
   output      logic                        initMode,
   output      logic [`NCH-1:0]             dout,
   output      logic [`NCH-1:0]             ledIn,
   output      logic [`NCH-1:0]             ledOut,
   output      logic                        hostTimeout,
   output      logic                        resetFlag,
   output      logic                        modWdBite
);
   chan_if ch ();

   logic                     coreRst_b;
   logic [31:0]              modWdCnt_reg;
   logic                     modWdBite_reg;
   logic                     st1_reg;
   logic                     st2_reg;
   logic                     st3_reg;
   logic [2:0]               strapWait_reg;
   logic                     initMode_reg;
   logic [7:0]               ledCfg_reg;
   logic [`NCH-1:0]          pon_reg;
   logic [`NCH-1:0]          safe_reg;
   logic [`NCH-1:0]          dout_reg;
   logic                     hwdArmed_reg;
   logic [7:0]               hwdLimit_reg;
   logic [31:0]              hwdTick_reg;
   logic [7:0]               hwdUnits_reg;
   logic                     hwdFlag_reg;
   logic                     hwdExpire;
   logic                     rstFlag_reg;
   logic                     ansValid_reg;
   logic [15:0]              ansData_reg;
   logic                     cfgWr_reg;
   logic [31:0]              flashCnt_reg;
   logic                     blink_reg;
   logic [7:0]               respBuf_reg [`RESP_MAX];
   logic [2:0]               respLen_reg;
   logic [2:0]               respIdx_reg;
   dio_supervisor_pkg::resp_e respState_reg;
   logic                     reqTake;
   logic                     cmdTake;

   // Checks whether a command is the given code.
   function automatic logic isCmd(input dio_supervisor_pkg::cmd_e c);
      isCmd = cmdValid && (cmdCode == c);
   endfunction

   // Core logic restarts on power-on and on a module watchdog bite.
   assign coreRst_b = rst_b && !modWdBite_reg;
   assign modWdBite = modWdBite_reg;

   // Module watchdog: the processor must kick it before the count runs out.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         modWdCnt_reg  <= '0;
         modWdBite_reg <= 1'b0;
      end else if (aliveKick || modWdBite_reg) begin
         modWdCnt_reg  <= '0;
         modWdBite_reg <= 1'b0;
      end else if (modWdCnt_reg == 32'(MODWD_CYC - 1)) begin
         modWdCnt_reg  <= '0;
         modWdBite_reg <= 1'b1;
      end else begin
         modWdCnt_reg  <= modWdCnt_reg + 32'd1;
      end
   end

   // Strap synchroniser and power-up capture; only a power-on reset re-reads it.
   // The third stage holds its reset level until the third edge, so capture waits for the fourth.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st1_reg       <= 1'b1;
         st2_reg       <= 1'b1;
         st3_reg       <= 1'b1;
         strapWait_reg <= '0;
         initMode_reg  <= 1'b0;
      end else begin
         st1_reg <= initStrap_b;
         st2_reg <= st1_reg;
         st3_reg <= st2_reg;
         if (strapWait_reg != 3'h4) begin
            strapWait_reg <= strapWait_reg + 3'h1;
            if (strapWait_reg == 3'h3 && st2_reg == st3_reg) begin
               initMode_reg <= !st3_reg;
            end
         end
      end
   end

   // Link settings: init mode overrides the stored ones.
   always_comb begin
      effId   = initMode_reg ? `INIT_ID : nvId;
      effBaud = initMode_reg ? `INIT_BAUD : nvBaud;
      effChk  = initMode_reg ? 1'b0 : nvChk;
   end
   assign initMode = initMode_reg;

   // Stored power-on and safe values survive a watchdog bite.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pon_reg  <= nvPowerOn;
         safe_reg <= nvSafe;
      end else begin
         if (isCmd(dio_supervisor_pkg::CMD_SET_PON)) begin
            pon_reg <= cmdData;
         end
         if (isCmd(dio_supervisor_pkg::CMD_SET_SAFE)) begin
            safe_reg <= cmdData;
         end
      end
   end

   // Host watchdog: one tick per unit, timeout after the programmed units.
   assign hwdExpire = hwdArmed_reg && !hwdFlag_reg
                      && hwdTick_reg == 32'(HWD_UNIT_CYC - 1)
                      && hwdUnits_reg == hwdLimit_reg - 8'h01;
   always_ff @(posedge clk) begin
      if (!coreRst_b) begin
         hwdArmed_reg <= 1'b0;
         hwdLimit_reg <= '0;
         hwdTick_reg  <= '0;
         hwdUnits_reg <= '0;
      end else begin
         if (isCmd(dio_supervisor_pkg::CMD_SET_TMO)) begin
            hwdArmed_reg <= cmdData != 8'h00;
            hwdLimit_reg <= cmdData;
         end
         if (isCmd(dio_supervisor_pkg::CMD_HOST_OK) || isCmd(dio_supervisor_pkg::CMD_SET_TMO)
             || !hwdArmed_reg || hwdFlag_reg) begin
            hwdTick_reg  <= '0;
            hwdUnits_reg <= '0;
         end else if (hwdTick_reg == 32'(HWD_UNIT_CYC - 1)) begin
            hwdTick_reg  <= '0;
            hwdUnits_reg <= hwdUnits_reg + 8'h01;
         end else begin
            hwdTick_reg <= hwdTick_reg + 32'd1;
         end
      end
   end

   // Timeout flag: expiry wins over a status reset in the same cycle.
   always_ff @(posedge clk) begin
      if (!coreRst_b) begin
         hwdFlag_reg <= 1'b0;
      end else if (hwdExpire) begin
         hwdFlag_reg <= 1'b1;
      end else if (isCmd(dio_supervisor_pkg::CMD_STAT_RST)) begin
         hwdFlag_reg <= 1'b0;
      end
   end
   assign hostTimeout = hwdFlag_reg;

   // Outputs: power-on value at reset, safe value on timeout, commands otherwise.
   always_ff @(posedge clk) begin
      if (!coreRst_b) begin
         dout_reg <= pon_reg;
      end else if (hwdExpire) begin
         dout_reg <= safe_reg;
      end else if (isCmd(dio_supervisor_pkg::CMD_SET_OUT) && !hwdFlag_reg) begin
         dout_reg <= cmdData;
      end
   end
   assign dout = dout_reg;

   // Reset status flag, cleared after the first query answer.
   always_ff @(posedge clk) begin
      if (!coreRst_b) begin
         rstFlag_reg <= 1'b1;
      end else if (isCmd(dio_supervisor_pkg::CMD_RST_QUERY)) begin
         rstFlag_reg <= 1'b0;
      end
   end
   assign resetFlag = rstFlag_reg;

   // Indicator blink time base.
   always_ff @(posedge clk) begin
      if (!coreRst_b) begin
         flashCnt_reg <= '0;
         blink_reg    <= 1'b0;
      end else if (flashCnt_reg == 32'(FLASH_CYC - 1)) begin
         flashCnt_reg <= '0;
         blink_reg    <= !blink_reg;
      end else begin
         flashCnt_reg <= flashCnt_reg + 32'd1;
      end
   end

   // Indicators follow activity and polarity; the output indicators flash after a timeout.
   always_comb begin
      for (int i = 0; i < `NCH; i++) begin
         ledOut[i] = hwdFlag_reg ? blink_reg
                   : (ledCfg_reg[`LED_OUT_BIT] ? dout_reg[i] : !dout_reg[i]);
         ledIn[i]  = ledCfg_reg[`LED_IN_BIT] ? ch.level[i] : !ch.level[i];
      end
   end

   // Channel controls: clears from host commands, counted edge from the data format field.
   assign cmdTake     = cmdValid;
   assign ch.edgeRise = dataFormatField[`FMT_EDGE_BIT];
   always_comb begin
      ch.cntClr = '0;
      ch.latClr = '0;
      if (isCmd(dio_supervisor_pkg::CMD_CNT_CLR)) begin
         ch.cntClr[cmdChan] = 1'b1;
      end
      if (isCmd(dio_supervisor_pkg::CMD_LAT_CLR)) begin
         ch.latClr[cmdChan] = 1'b1;
      end
   end

   din_channels u_chan (
      .clk   (clk),
      .rst_b (coreRst_b),
      .din   (din),
      .ch    (ch)
   );

   // One-cycle answers to query commands.
   always_ff @(posedge clk) begin
      if (!coreRst_b) begin
         ansValid_reg <= 1'b0;
         ansData_reg  <= '0;
         cfgWr_reg    <= 1'b0;
      end else begin
         ansValid_reg <= 1'b0;
         cfgWr_reg    <= isCmd(dio_supervisor_pkg::CMD_CFG_WRITE)
                         && initMode_reg && cmdId == `INIT_ID;
         if (cmdTake) begin
            unique case (cmdCode)
               dio_supervisor_pkg::CMD_RST_QUERY: begin
                  ansValid_reg <= 1'b1;
                  ansData_reg  <= {15'h0000, rstFlag_reg};
               end
               dio_supervisor_pkg::CMD_CNT_READ: begin
                  ansValid_reg <= 1'b1;
                  ansData_reg  <= ch.cnt[cmdChan];
               end
               dio_supervisor_pkg::CMD_LAT_READ: begin
                  ansValid_reg <= 1'b1;
                  ansData_reg  <= {8'h00, ch.latch};
               end
               dio_supervisor_pkg::CMD_CFG_READ: begin
                  ansValid_reg <= 1'b1;
                  ansData_reg  <= {nvId, 7'h00, nvChk};
               end
               default: begin
                  ansValid_reg <= 1'b0;
               end
            endcase
         end
      end
   end
   assign ansValid    = ansValid_reg;
   assign ansData     = ansData_reg;
   assign cfgWrStrobe = cfgWr_reg;

   // LED configuration requests are taken while no reply is pending.
   assign reqReady = respState_reg == dio_supervisor_pkg::RS_IDLE;
   assign reqTake  = reqValid && reqReady;

   // Builds the reply bytes and the stored LED configuration.
   always_ff @(posedge clk) begin
      if (!coreRst_b) begin
         ledCfg_reg  <= '0;
         respLen_reg <= '0;
         for (int i = 0; i < `RESP_MAX; i++) begin
            respBuf_reg[i] <= '0;
         end
      end else if (reqTake) begin
         respBuf_reg[0] <= effId;
         respBuf_reg[1] <= `FN_ERR;
         respBuf_reg[2] <= `EX_FUNC;
         respLen_reg    <= 3'd3;
         if (reqFunc == `FN_LED && reqSub == `SUB_GET) begin
            respBuf_reg[1] <= `FN_LED;
            respBuf_reg[2] <= `SUB_GET;
            respBuf_reg[3] <= ledCfg_reg;
            respLen_reg    <= 3'd4;
         end else if (reqFunc == `FN_LED && reqSub == `SUB_SET) begin
            if ((reqData & ~`LED_USED) != 8'h00) begin
               respBuf_reg[2] <= `EX_VAL;
            end else begin
               ledCfg_reg     <= reqData;
               respBuf_reg[1] <= `FN_LED;
               respBuf_reg[2] <= `SUB_SET;
               for (int i = 3; i < `RESP_MAX; i++) begin
                  respBuf_reg[i] <= `OK_BYTE;
               end
               respLen_reg <= 3'd7;
            end
         end
      end
   end

   // Reply sender: one byte per accepted beat.
   always_ff @(posedge clk) begin
      if (!coreRst_b) begin
         respState_reg <= dio_supervisor_pkg::RS_IDLE;
         respIdx_reg   <= '0;
      end else begin
         unique case (respState_reg)
            dio_supervisor_pkg::RS_IDLE: begin
               respIdx_reg <= '0;
               if (reqTake) begin
                  respState_reg <= dio_supervisor_pkg::RS_SEND;
               end
            end
            dio_supervisor_pkg::RS_SEND: begin
               if (respReady && respLast) begin
                  respState_reg <= dio_supervisor_pkg::RS_IDLE;
               end else if (respReady) begin
                  respIdx_reg <= respIdx_reg + 3'd1;
               end
            end
         endcase
      end
   end
   assign respValid = respState_reg == dio_supervisor_pkg::RS_SEND;
   assign respByte  = respBuf_reg[respIdx_reg];
   assign respLast  = respValid && (respIdx_reg == respLen_reg - 3'd1);

   a_get_reply: assert property (@(posedge clk) disable iff (!coreRst_b)
      reqTake && reqFunc == `FN_LED && reqSub == `SUB_GET
      |=> respValid && respByte == effId ##0 respLen_reg == 3'd4)
      else $error("LED read reply has the wrong shape.");

   a_out_polarity: assert property (@(posedge clk) disable iff (!coreRst_b)
      !hwdFlag_reg |-> ledOut[0] == (ledCfg_reg[`LED_OUT_BIT] ~^ dout_reg[0]))
      else $error("Output indicator polarity is wrong.");

   a_in_polarity: assert property (@(posedge clk) disable iff (!coreRst_b)
      ledIn[0] == (ledCfg_reg[`LED_IN_BIT] ~^ ch.level[0]))
      else $error("Input indicator polarity is wrong.");

   a_err_reply: assert property (@(posedge clk) disable iff (!coreRst_b)
      reqTake && reqFunc != `FN_LED
      |=> respBuf_reg[1] == `FN_ERR && respBuf_reg[2] == `EX_FUNC && respLen_reg == 3'd3)
      else $error("Bad function did not give the error reply.");

   a_set_store: assert property (@(posedge clk) disable iff (!coreRst_b)
      reqTake && reqFunc == `FN_LED && reqSub == `SUB_SET && reqData[7:2] == 6'h00
      |=> ledCfg_reg == $past(reqData) && respLen_reg == 3'd7 && respBuf_reg[3] == `OK_BYTE)
      else $error("LED configuration write not stored.");

   a_init_link: assert property (@(posedge clk) disable iff (!rst_b)
      initMode_reg |-> effId == `INIT_ID && effBaud == `INIT_BAUD && !effChk)
      else $error("Init mode link settings are wrong.");

   a_init_hold: assert property (@(posedge clk) disable iff (!rst_b)
      strapWait_reg == 3'h4 |=> $stable(initMode_reg))
      else $error("Init mode changed without a power cycle.");

   a_safe_out: assert property (@(posedge clk) disable iff (!coreRst_b)
      hwdExpire |=> hwdFlag_reg && dout_reg == $past(safe_reg) ##1 dout_reg == $past(dout_reg))
      else $error("Timeout did not force safe outputs.");

   a_wd_bite: assert property (@(posedge clk) disable iff (!rst_b)
      modWdBite_reg |=> rstFlag_reg && dout_reg == pon_reg)
      else $error("Watchdog bite did not restart the module.");

   a_flag_clear: assert property (@(posedge clk) disable iff (!coreRst_b)
      isCmd(dio_supervisor_pkg::CMD_RST_QUERY) |=> ansValid_reg && !rstFlag_reg)
      else $error("Reset flag not answered and cleared.");
endmodule

/* File: dio_supervisor_cfg.svh */
// Constants of the I/O module supervisor: codes, field positions and timing.
`ifndef DIO_SUPERVISOR_CFG_SVH
`define DIO_SUPERVISOR_CFG_SVH
`define NCH          8
`define CNTW         16
`define FN_LED       8'h46
`define FN_ERR       8'hc6
`define SUB_SET      8'h80
`define SUB_GET      8'h81
`define EX_FUNC      8'h01
`define EX_ADDR      8'h02
`define EX_VAL       8'h03
`define OK_BYTE      8'h00
`define LED_IN_BIT   0
`define LED_OUT_BIT  1
`define LED_USED     8'h03
`define FMT_EDGE_BIT 7
`define INIT_ID      8'h00
`define INIT_BAUD    18'd9600
`define RESP_MAX     7
`define CLK_HZ       250000000
`define HWD_UNIT_MS  100
`define MODWD_MS     500
`define FLASH_MS     250
`define MS_CYC(ms)   ((ms) * (`CLK_HZ / 1000))
`endif

/* File: dio_supervisor_pkg.sv */
// Types shared by the supervisor modules.
package dio_supervisor_pkg;
   typedef enum logic [3:0] {
      CMD_SET_OUT, CMD_SET_TMO, CMD_HOST_OK, CMD_STAT_RST,
      CMD_RST_QUERY, CMD_CNT_READ, CMD_CNT_CLR, CMD_LAT_READ,
      CMD_LAT_CLR, CMD_SET_PON, CMD_SET_SAFE, CMD_CFG_READ,
      CMD_CFG_WRITE
   } cmd_e;
   typedef enum {RS_IDLE, RS_SEND} resp_e;
endpackage

/* File: chan_if.sv */
// Signals between the supervisor core and the input channel block.
`timescale 1ns/1ps
`include "dio_supervisor_cfg.svh"
interface chan_if;
   logic                 edgeRise;
   logic [`NCH-1:0]      cntClr;
   logic [`NCH-1:0]      latClr;
   logic [`NCH-1:0]      level;
   logic [`NCH-1:0]      latch;
   logic [`CNTW-1:0]     cnt [`NCH];
   modport core (output edgeRise, cntClr, latClr, input level, latch, cnt);
   modport chan (input edgeRise, cntClr, latClr, output level, latch, cnt);
endinterface

/* File: din_channels.sv */
// Input channels: pin synchroniser, edge counter and pulse latch each.
`timescale 1ns/1ps
`include "dio_supervisor_cfg.svh"
module din_channels (
   input  wire logic            clk,
   input  wire logic            rst_b,
   input  wire logic [`NCH-1:0] din,
   chan_if.chan                 ch
);
   // Picks the counted edge from the old and new filtered level.
   function automatic logic edgeHit(input logic rise, input logic old, input logic cur);
      edgeHit = rise ? (!old && cur) : (old && !cur);
   endfunction

   logic [`NCH-1:0] s1_reg;
   logic [`NCH-1:0] s2_reg;
   logic [`NCH-1:0] s3_reg;
   logic [`NCH-1:0] filt_reg;
   logic [`NCH-1:0] hit;

   // Three-stage synchroniser; the level moves only when stages two and three agree.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s1_reg   <= '0;
         s2_reg   <= '0;
         s3_reg   <= '0;
         filt_reg <= '0;
      end else begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         for (int i = 0; i < `NCH; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               filt_reg[i] <= s3_reg[i];
            end
         end
      end
   end

   assign ch.level = filt_reg;

   // Edge strobe per channel from the filtered level and the current edge choice.
   always_comb begin
      for (int i = 0; i < `NCH; i++) begin
         hit[i] = edgeHit(ch.edgeRise, filt_reg[i], s3_reg[i]) && (s2_reg[i] == s3_reg[i]);
      end
   end

   // Counters and latches; a pulse in the clear cycle is kept.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ch.latch <= '0;
         for (int i = 0; i < `NCH; i++) begin
            ch.cnt[i] <= '0;
         end
      end else begin
         for (int i = 0; i < `NCH; i++) begin
            if (ch.cntClr[i]) begin
               ch.cnt[i] <= hit[i] ? `CNTW'(1) : '0;
            end else if (hit[i]) begin
               ch.cnt[i] <= ch.cnt[i] + `CNTW'(1);
            end
            if (hit[i]) begin
               ch.latch[i] <= 1'b1;
            end else if (ch.latClr[i]) begin
               ch.latch[i] <= 1'b0;
            end
         end
      end
   end

   // Count and latch checks repeated on every channel, so any pin that toggles is covered.
   for (genvar g = 0; g < `NCH; g++) begin : g_chk
      a_count_step: assert property (@(posedge clk) disable iff (!rst_b)
         hit[g] && !ch.cntClr[g] |=> ch.cnt[g] == $past(ch.cnt[g]) + `CNTW'(1))
         else $error("Channel count did not step on its edge.");

      a_latch_hold: assert property (@(posedge clk) disable iff (!rst_b)
         ch.latch[g] && !ch.latClr[g] |=> ch.latch[g])
         else $error("Pulse latch dropped without a clear.");
   end
endmodule

/* File: host_link_model.sv */
// Host side of the reply stream: takes reply bytes and stalls every third cycle.
`timescale 1ns/1ps
module host_link_model (
   input  wire logic       clk,
   input  wire logic       respValid,
   input  wire logic       respLast,
   input  wire logic [7:0] respByte,
   output      logic       respReady
);
   logic [7:0] got [$];
   int         n = 0;
   int         lastAt = 0;
   initial respReady = 1'b1;
   // Takes a byte at each edge with ready high, then redraws ready a little later.
   always @(posedge clk) begin
      if (respValid && respReady) begin
         got.push_back(respByte);
         lastAt = respLast ? got.size() : 0;
      end
      n++;
      respReady <= #1 (n % 3 != 2);
   end
endmodule

/* File: dio_module_supervisor_tb_top.sv */
// Self-checking bench for the I/O module supervisor.
`timescale 1ns/1ps
`define CHK(s, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %s exp %0h got %0h", s, e, g); end end
module dio_module_supervisor_tb_top;
   logic        clk = 0, rst_b = 0, initStrap_b = 1, aliveKick = 0, nvChk = 1, reqValid = 0;
   logic        cmdValid = 0, reqReady, respValid, respReady, respLast, ansValid, cfgWrStrobe;
   logic        initMode, hostTimeout, resetFlag, modWdBite, effChk, kickOn = 1, wr;
   logic [7:0]  din = 0, nvId = 8'h2c, nvPowerOn = 0, nvSafe = 0, dataFormatField = 8'h80;
   logic [7:0]  reqFunc = 0, reqSub = 0, reqData = 0, cmdData = 0, cmdId = 0, respByte, effId;
   logic [7:0]  dout, ledIn, ledOut, pon, safe, cfg;
   logic [17:0] nvBaud = 18'd19200, effBaud;
   logic [15:0] ansData;
   logic [2:0]  cmdChan = 3'h2;
   dio_supervisor_pkg::cmd_e cmdCode = dio_supervisor_pkg::CMD_HOST_OK;
   int          num_errors = 0, comparisons = 0, seed = 32'hd3dfec0c, n, k;
   dio_module_supervisor #(.MODWD_CYC(200), .HWD_UNIT_CYC(10), .FLASH_CYC(8)) dut (.clk, .rst_b,
      .initStrap_b, .din, .aliveKick, .nvId, .nvBaud, .nvChk, .nvPowerOn, .nvSafe,
      .dataFormatField, .reqValid, .reqReady, .reqFunc, .reqSub, .reqData, .respValid,
      .respReady, .respByte, .respLast, .cmdValid, .cmdCode, .cmdChan, .cmdData, .cmdId,
      .ansValid, .ansData, .cfgWrStrobe, .effId, .effBaud, .effChk, .initMode, .dout, .ledIn,
      .ledOut, .hostTimeout, .resetFlag, .modWdBite);
   host_link_model host (.clk, .respValid, .respLast, .respByte, .respReady);
   // Clock and a processor heartbeat that can be stopped to starve the module watchdog.
   always #2 clk = ~clk;
   always begin
      repeat (50) @(posedge clk);
      #1 aliveKick = kickOn;
      @(posedge clk);
      #1 aliveKick = 0;
   end
   task automatic tick(int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   task automatic power_up(logic strap);
      rst_b = 0;
      initStrap_b = strap;
      nvPowerOn = $random(seed);
      nvSafe = $random(seed);
      tick(2);
      rst_b = 1;
      tick(1);
      `CHK("dout", nvPowerOn, dout)
      `CHK("rflag", 1'b1, resetFlag)
      tick(4);
   endtask
   // Sends one request, holds it until taken, then compares the whole reply.
   task automatic req(logic [7:0] f, logic [7:0] s, logic [7:0] d, logic [7:0] e [$]);
      host.got.delete();
      reqFunc = f;
      reqSub = s;
      reqData = d;
      reqValid = 1;
      for (n = 0; n < 20 && !reqReady; n++) tick(1);
      if (!reqReady) num_errors++;
      tick(1);
      reqValid = 0;
      for (n = 0; n < 40 && host.got.size() < e.size(); n++) tick(1);
      `CHK("len", e.size(), host.got.size())
      foreach (e[j]) `CHK("byte", e[j], host.got[j])
      `CHK("last", e.size(), host.lastAt)
   endtask
   // Sends one command, checks the answer pulse, then lets an idle edge pass.
   task automatic cmd(dio_supervisor_pkg::cmd_e c, logic [7:0] d, logic [7:0] id = 0);
      logic expAns;
      expAns = c inside {dio_supervisor_pkg::CMD_RST_QUERY, dio_supervisor_pkg::CMD_CNT_READ,
                         dio_supervisor_pkg::CMD_LAT_READ, dio_supervisor_pkg::CMD_CFG_READ};
      cmdCode = c;
      cmdData = d;
      cmdId = id;
      cmdValid = 1;
      tick(1);
      cmdValid = 0;
      wr = cfgWrStrobe;
      `CHK("ans", expAns, ansValid)
      tick(1);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Main sequence.
   initial begin
      power_up(1);
      `CHK("id", nvId, effId)
      `CHK("init", 1'b0, initMode)
      cmd(dio_supervisor_pkg::CMD_RST_QUERY, 0);
      `CHK("rq1", 16'h1, ansData)
      cmd(dio_supervisor_pkg::CMD_RST_QUERY, 0);
      `CHK("rq2", 16'h0, ansData)
      cfg = $random(seed) & 8'h03;
      req(8'h46, 8'h80, cfg, {nvId, 8'h46, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00});
      req(8'h46, 8'h81, 0, {nvId, 8'h46, 8'h81, cfg});
      req(8'h46, 8'h80, 8'h04, {nvId, 8'hc6, 8'h03});
      req(8'h12, 8'h81, 0, {nvId, 8'hc6, 8'h01});
      req(8'h46, 8'h55, 0, {nvId, 8'hc6, 8'h01});
      `CHK("ledIn", cfg[0] ? din : ~din, ledIn)
      `CHK("ledOut", cfg[1] ? dout : ~dout, ledOut)
      // Rising edges only: a falling-edge counter would be one short.
      k = 1 + ($unsigned($random(seed)) % 4);
      repeat (k) begin
         din[2] = 0;
         tick(6);
         din[2] = 1;
         tick(6);
      end
      cmd(dio_supervisor_pkg::CMD_CNT_READ, 0);
      `CHK("cnt", k[15:0], ansData)
      din[2] = 0;
      tick(6);
      cmd(dio_supervisor_pkg::CMD_LAT_READ, 0);
      `CHK("lat", 16'h4, ansData)
      cmd(dio_supervisor_pkg::CMD_CNT_CLR, 8'hff);
      cmd(dio_supervisor_pkg::CMD_LAT_CLR, 8'hff);
      cmd(dio_supervisor_pkg::CMD_CNT_READ, 0);
      `CHK("cnt0", 16'h0, ansData)
      cmd(dio_supervisor_pkg::CMD_LAT_READ, 0);
      `CHK("lat0", 16'h0, ansData)
      pon = $random(seed);
      safe = $random(seed);
      cmd(dio_supervisor_pkg::CMD_SET_PON, pon);
      cmd(dio_supervisor_pkg::CMD_SET_SAFE, safe);
      cmd(dio_supervisor_pkg::CMD_SET_OUT, ~pon);
      `CHK("out", ~pon, dout)
      `CHK("hto", 1'b0, hostTimeout)
      cmd(dio_supervisor_pkg::CMD_SET_TMO, 8'h02);
      repeat (4) begin
         tick(12);
         cmd(dio_supervisor_pkg::CMD_HOST_OK, 0);
      end
      `CHK("hto0", 1'b0, hostTimeout)
      tick(25);
      `CHK("hto1", 1'b1, hostTimeout)
      `CHK("safe", safe, dout)
      cfg = ledOut;
      tick(8);
      `CHK("flash", ~cfg, ledOut)
      cmd(dio_supervisor_pkg::CMD_SET_OUT, 0);
      `CHK("ign", safe, dout)
      cmd(dio_supervisor_pkg::CMD_SET_TMO, 0);
      cmd(dio_supervisor_pkg::CMD_STAT_RST, 0);
      tick(1);
      `CHK("hto2", 1'b0, hostTimeout)
      kickOn = 0;
      for (n = 0; n < 400 && !modWdBite; n++) tick(1);
      kickOn = 1;
      `CHK("bite", 1'b1, modWdBite)
      tick(2);
      `CHK("pon", pon, dout)
      `CHK("rflag2", 1'b1, resetFlag)
      power_up(0);
      `CHK("init1", 1'b1, initMode)
      `CHK("id0", 8'h00, effId)
      `CHK("baud", 18'd9600, effBaud)
      `CHK("chk", 1'b0, effChk)
      cmd(dio_supervisor_pkg::CMD_CFG_READ, 0);
      `CHK("cfg", {nvId, 7'h00, nvChk}, ansData)
      cmd(dio_supervisor_pkg::CMD_CFG_WRITE, 0, 8'h01);
      `CHK("wr1", 1'b0, wr)
      cmd(dio_supervisor_pkg::CMD_CFG_WRITE, 0, 8'h00);
      `CHK("wr0", 1'b1, wr)
      power_up(1);
      `CHK("init2", 1'b0, initMode)
      cmd(dio_supervisor_pkg::CMD_CFG_WRITE, 0, 8'h00);
      `CHK("wrn", 1'b0, wr)
      wrap_up;
   end
   // Cuts a hang short.
   initial begin
      #200000;
      num_errors++;
      wrap_up;
   end
endmodule
